// >>> pkg/serial_cfg_regs.svh
`ifndef SERIAL_CFG_REGS_SVH
`define SERIAL_CFG_REGS_SVH
`define SERIAL_CFG_OFFSET       8'h30
`define PRODUCT_ID_OFFSET       8'h3E
`define TARGET_ADDR_OFFSET      8'h3F
`define SERIAL_CFG_RESET        8'h00
`define PRODUCT_ID_RESET        8'h00
`define TARGET_ADDR_RESET       8'h00
`define STATUS_FMT_BIT          7
`define DATA_WIDTH_BIT          6
`define CRC_LEN_HI              5
`define CRC_LEN_LO              4
`define CRC_SEED_HI             3
`define CRC_SEED_LO             0
`define TARGET_ADDR_DEFAULT     7'h60
`define TARGET_ADDR_DEFAULT_RD  8'h60
`define CRC8_POLY               8'h2F
`define CRC8_SEED_DEFAULT       8'hFF
`define CRC8_SEED_UPPER         4'hF
`define CRC4_POLY               8'h01
`define CRC4_SEED_DEFAULT       8'h0A
`define CRC3_POLY               8'h03
`define CRC3_SEED_DEFAULT       8'h07
`define PRODUCT_ID_BUILTIN      8'h5A
`endif

// >>> pkg/serial_cfg_pkg.sv
package serial_cfg_pkg;
   typedef enum logic [2:0] {
      MODE_FOUR_WIRE = 3'b001,
      MODE_TWO_WIRE  = 3'b010,
      MODE_OTHER     = 3'b100
   } if_mode_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [1:0] crc_len;
      logic [7:0] poly;
      logic [7:0] seed;
      logic       status_alt;
      logic       data_16bit;
   } crc_cfg_t;
endpackage

// >>> rtl/crc_select.sv
`timescale 1ns/1ps
`include "serial_cfg_regs.svh"
module crc_select (
   input  wire logic [7:0]           cfg_in,
   output serial_cfg_pkg::crc_cfg_t  sel_out
);
   import serial_cfg_pkg::*;
   wire logic [1:0] len_w  = cfg_in[`CRC_LEN_HI:`CRC_LEN_LO];
   wire logic [3:0] seed_w = cfg_in[`CRC_SEED_HI:`CRC_SEED_LO];
   wire logic       zero_w = (seed_w == 4'h0);
   wire logic [7:0] s8_w   = zero_w ? `CRC8_SEED_DEFAULT : {`CRC8_SEED_UPPER, seed_w};
   wire logic [7:0] s4_w   = zero_w ? `CRC4_SEED_DEFAULT : {4'h0, seed_w};
   wire logic [7:0] s3_w   = zero_w ? `CRC3_SEED_DEFAULT : {5'h00, seed_w[2:0]};
   assign sel_out.crc_len    = len_w;
   assign sel_out.poly       = (len_w == 2'b00) ? `CRC8_POLY :
                               (len_w == 2'b01) ? `CRC4_POLY : `CRC3_POLY;
   assign sel_out.seed       = (len_w == 2'b00) ? s8_w : (len_w == 2'b01) ? s4_w : s3_w;
   assign sel_out.status_alt = cfg_in[`STATUS_FMT_BIT];
   assign sel_out.data_16bit = cfg_in[`DATA_WIDTH_BIT];
endmodule

// >>> rtl/serial_if_config_regs.sv
`timescale 1ns/1ps
`include "serial_cfg_regs.svh"
// Behaviour
// - status format bit picks alternate status format
// - other modes store fields, crc config no effect
// - data width bit: 0 twelve, 1 sixteen
// - length 00: eight-bit crc, seed FF default
// - eight-bit nonzero seed: 1111 then field
// - length 01: four-bit crc, seed 1010 default
// - length 1x: three-bit crc, seed 111 default
// - new length applies from next command
// - new seed applies from next command
// - eight-bit product identifier, rw in all modes
// - stored zero reads back built-in identifier
// - zero in low seven bits: use and read 60
// - otherwise low seven bits, read full byte
// - all three registers covered by array check
module serial_if_config_regs #(
   parameter logic [7:0] BUILTIN_ID = `PRODUCT_ID_BUILTIN  // arbitrary value
) (
   input  wire logic                      ref_clk_in,
   input  wire logic                      rst_n_in,
   input  wire serial_cfg_pkg::if_mode_t  mode_in,
   input  wire serial_cfg_pkg::reg_req_t  req_in,
   input  wire logic                      cmd_start_in,
   output serial_cfg_pkg::crc_cfg_t       link_cfg_out,
   output logic [7:0]                     rdata_out,
   output logic                           rvalid_out,
   output logic [6:0]                     target_addr_out,
   output logic [7:0]                     array_sum_out
);
   import serial_cfg_pkg::*;

   // zero would read back as itself and hide the stored-zero substitution
   if (BUILTIN_ID == 8'h00) begin : g_bad_builtin_id
      $error("builtin identifier must be nonzero");
   end

   logic [7:0] cfg_reg;
   logic [7:0] pid_reg;
   logic [7:0] taddr_reg;
   logic [7:0] rdata_reg;
   logic       rvalid_reg;
   crc_cfg_t   active_reg;
   crc_cfg_t   pending_w;
   crc_cfg_t   idle_cfg_w;

   wire logic hit_cfg_w   = (req_in.addr == `SERIAL_CFG_OFFSET);
   wire logic hit_pid_w   = (req_in.addr == `PRODUCT_ID_OFFSET);
   wire logic hit_taddr_w = (req_in.addr == `TARGET_ADDR_OFFSET);
   wire logic four_wire_w = (mode_in == MODE_FOUR_WIRE);
   wire logic taddr_dflt_w = (taddr_reg[6:0] == 7'h00);

   wire logic [7:0] pid_rd_w   = (pid_reg == 8'h00) ? BUILTIN_ID : pid_reg;
   wire logic [7:0] taddr_rd_w = taddr_dflt_w ? `TARGET_ADDR_DEFAULT_RD
                                              : taddr_reg;
   wire logic [7:0] rd_mux_w   = hit_cfg_w   ? cfg_reg :
                                 hit_pid_w   ? pid_rd_w :
                                 hit_taddr_w ? taddr_rd_w : 8'h00;

   crc_select u_crc_select (
      .cfg_in  (cfg_reg),
      .sel_out (pending_w)
   );

   assign idle_cfg_w = '0;

   // writes land in every mode; crc settings reach the link only in four-wire mode, target address in every mode
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_reg   <= `SERIAL_CFG_RESET;
         pid_reg   <= `PRODUCT_ID_RESET;
         taddr_reg <= `TARGET_ADDR_RESET;
      end else if (req_in.wr) begin
         if (hit_cfg_w) begin
            cfg_reg <= req_in.wdata;
         end
         if (hit_pid_w) begin
            pid_reg <= req_in.wdata;
         end
         if (hit_taddr_w) begin
            taddr_reg <= req_in.wdata;
         end
      end
   end

   // a frame in flight keeps its crc; new settings wait for the next command
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // reset settings decode to eight-bit crc with all-ones seed
         active_reg <= '{2'b00, `CRC8_POLY, `CRC8_SEED_DEFAULT, 1'b0, 1'b0};
      end else if (cmd_start_in) begin
         active_reg <= pending_w;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= req_in.rd ? rd_mux_w : rdata_reg;
         rvalid_reg <= req_in.rd;
      end
   end

   assign rdata_out       = rdata_reg;
   assign rvalid_out      = rvalid_reg;
   // all-zero crc config outside four-wire mode keeps settings inert there
   assign link_cfg_out    = four_wire_w ? active_reg : idle_cfg_w;
   assign target_addr_out = taddr_dflt_w ? `TARGET_ADDR_DEFAULT
                                         : taddr_reg[6:0];
   // simple xor fold; the array checker compares it against its stored copy
   assign array_sum_out   = cfg_reg ^ pid_reg ^ taddr_reg;

   a_pid_default: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (req_in.rd && hit_pid_w && pid_reg == 8'h00) |=> rdata_out == BUILTIN_ID)
      else $error("product id default readback wrong");
   a_pid_stored: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (req_in.wr && hit_pid_w && req_in.wdata != 8'h00) ##1 (req_in.rd && hit_pid_w)
      |=> rdata_out == $past(req_in.wdata, 2))
      else $error("product id readback mismatch");
   a_taddr_default: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (taddr_reg[6:0] == 7'h00) |-> target_addr_out == 7'h60)
      else $error("default target address wrong");
   a_taddr_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (req_in.rd && hit_taddr_w && taddr_reg[6:0] != 7'h00) |=> rdata_out == $past(taddr_reg))
      else $error("target address readback wrong");
   a_taddr_80: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (req_in.rd && hit_taddr_w && taddr_reg == 8'h80) |=> rdata_out == 8'h60)
      else $error("stored 80 not read as default");
   a_crc_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!cmd_start_in) |=> $stable(active_reg))
      else $error("crc config changed mid command");
   a_crc8_seed: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (cmd_start_in && cfg_reg[5:0] == 6'h00) |=> active_reg.seed == 8'hFF
      && active_reg.poly == 8'h2F)
      else $error("default crc8 seed wrong");
   a_crc4_seed: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (cmd_start_in && cfg_reg[5:0] == 6'h10) |=> active_reg.seed == 8'h0A)
      else $error("default crc4 seed wrong");
   a_other_mode: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!four_wire_w) |-> link_cfg_out == '0)
      else $error("crc config active outside four-wire mode");

   c_cfg_write: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      req_in.wr && hit_cfg_w ##1 cmd_start_in);
   c_pid_read: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      req_in.rd && hit_pid_w);
   c_taddr_set: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      req_in.wr && hit_taddr_w && req_in.wdata == 8'h80);
endmodule

// >>> verification/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire logic                  ref_clk_in,
   input  wire logic                  rvalid_in,
   input  wire logic [7:0]            rdata_in,
   output serial_cfg_pkg::reg_req_t   req_out,
   output logic                       cmd_start_out
);
   import serial_cfg_pkg::*;
   initial begin
      req_out = '0;
      cmd_start_out = 1'b0;
   end
   // one strobe per request, always an idle edge between requests
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
      @(posedge ref_clk_in);
      req_out <= '{w, ~w, a, d};
      @(posedge ref_clk_in);
      // released bus shows no stale address or data
      req_out <= '{1'b0, 1'b0, ~a, ~d};
      #1;
      q = rdata_in;
      v = rvalid_in;
   endtask
   task automatic cmd();
      @(posedge ref_clk_in);
      cmd_start_out <= 1'b1;
      @(posedge ref_clk_in);
      cmd_start_out <= 1'b0;
   endtask
endmodule

// >>> verification/tb_serial_if_config_regs.sv
`timescale 1ns/1ps
module tb_serial_if_config_regs;
   import serial_cfg_pkg::*;
   localparam logic [7:0] BID = 8'hA7;  // arbitrary value
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   if_mode_t    mode = MODE_FOUR_WIRE;
   if_mode_t    md[3] = '{MODE_FOUR_WIRE, MODE_TWO_WIRE, MODE_OTHER};
   reg_req_t    req;
   logic        cmd, rv, v;
   crc_cfg_t    link;
   logic [7:0]  rdata, sum, q, lat, a, d;
   logic [7:0]  m[3];
   logic [7:0]  ad[4] = '{8'h30, 8'h3E, 8'h3F, 8'h5C};
   logic [6:0]  taddr;
   logic [31:0] r;
   int          err_count = 0;
   int          compares = 0;
   initial forever #5 clk = ~clk;
   serial_if_config_regs #(.BUILTIN_ID(BID)) DUT (.ref_clk_in(clk), .rst_n_in(rst_n),
      .mode_in(mode), .req_in(req), .cmd_start_in(cmd), .link_cfg_out(link),
      .rdata_out(rdata), .rvalid_out(rv), .target_addr_out(taddr), .array_sum_out(sum));
   host_model host (.ref_clk_in(clk), .rvalid_in(rv), .rdata_in(rdata),
      .req_out(req), .cmd_start_out(cmd));
   task automatic chk(string n, logic [19:0] e, logic [19:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   function automatic logic [7:0] erd(logic [7:0] x);
      case (x)
         8'h30: return m[0];
         8'h3E: return m[1] == 8'h00 ? BID : m[1];
         8'h3F: return m[2][6:0] == 7'h00 ? 8'h60 : m[2];
         default: return 8'h00;
      endcase
   endfunction
   function automatic crc_cfg_t ecfg(logic [7:0] c);
      logic [3:0] s;
      crc_cfg_t   e;
      s = c[3:0];
      case (c[5:4])
         2'b00: e = '{c[5:4], 8'h2F, s == 0 ? 8'hFF : {4'hF, s}, c[7], c[6]};
         2'b01: e = '{c[5:4], 8'h01, s == 0 ? 8'h0A : {4'h0, s}, c[7], c[6]};
         default: e = '{c[5:4], 8'h03, s == 0 ? 8'h07 : {5'h00, s[2:0]}, c[7], c[6]};
      endcase
      return mode == MODE_FOUR_WIRE ? e : crc_cfg_t'(0);
   endfunction
   task automatic sweep();
      for (int i = 0; i < 4; i++) begin
         host.xfer(1'b0, ad[i], 8'h00, q, v);
         chk("rvalid", 1'b1, v);
         chk("rdata", erd(ad[i]), q);
      end
      chk("target", erd(8'h3F) == 8'h60 ? 7'h60 : m[2][6:0], taddr);
      chk("sum", m[0] ^ m[1] ^ m[2], sum);
      chk("link", ecfg(lat), link);
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200us;
      err_count++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'h2DFC));
      m = '{8'h00, 8'h00, 8'h00};
      lat = 8'h00;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      sweep();
      repeat (80) begin
         r = $urandom;
         a = r[1:0] == 2'd3 ? {4'h5, r[15:12]} : ad[r[1:0]];
         d = r[9:8] == 0 ? 8'h00 : r[9:8] == 1 ? 8'h80 : r[23:16] & (r[10] ? 8'hF0 : 8'hFF);
         host.xfer(1'b1, a, d, q, v);
         if (r[1:0] != 2'd3) m[r[1:0]] = d;
         sweep(); // new settings held until next command
         @(posedge clk);
         mode <= md[r[27:26] % 3];
         host.cmd();
         lat = m[0];
         sweep();
      end
      wrap_up();
   end
endmodule
